// ---- cpu_system_pointer_registers.sv ----
// Module: window, bank, index and row-pointer system registers with an AHB-Lite register port
`timescale 1ns/10ps

module cpu_system_pointer_registers
(
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    input wire logic WATCHDOG_RESET_IN,
    input wire logic CE_RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic REGFILE_READ_INSTR_IN,
    input wire logic REGFILE_WRITE_INSTR_IN,
    input wire logic [sysptr_pkg::REGFILE_ADDR_W-1:0] REGFILE_OPERAND_IN,
    input wire logic [3:0] REGFILE_READ_DATA_IN,
    output logic [sysptr_pkg::REGFILE_ADDR_W-1:0] REGFILE_ADDR_OUT,
    output logic REGFILE_WRITE_EN_OUT,
    output logic [3:0] REGFILE_WRITE_DATA_OUT,
    input wire logic DM_ACCESS_IN,
    input wire sysptr_pkg::dm_addr_s DM_ADDR_IN,
    output sysptr_pkg::dm_addr_s DM_REAL_ADDR_OUT,
    input wire logic GR_INDIRECT_IN,
    input wire sysptr_pkg::dm_addr_s GR_INDIRECT_ADDR_IN,
    output sysptr_pkg::dm_addr_s GR_REAL_ADDR_OUT,
    output logic [3:0] DATA_BANK_OUT,
    output logic [sysptr_pkg::INDEX_W-1:0] INDEX_VALUE_OUT,
    output logic INDEX_MODIFY_ENABLE_OUT,
    output logic [sysptr_pkg::ROW_POINTER_W-1:0] ROW_POINTER_OUT,
    output logic ROW_POINTER_ENABLE_OUT
);
    import sysptr_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [3:0] window_staging_ff;
    logic [3:0] data_bank_select_ff;
    logic [3:0] index_high_ff;
    logic [3:0] index_mid_ff;
    logic [3:0] index_low_ff;
    logic [3:0] program_status_word_ff;
    logic fetch_pending_ff;
    logic [REGFILE_ADDR_W-1:0] regfile_addr_ff;
    logic regfile_wen_ff;
    logic [3:0] regfile_wdata_ff;
    bus_phase_s phase_ff;
    bus_phase_s nxt_phase;
    dm_addr_s dm_real_ff;
    dm_addr_s gr_real_ff;
    logic any_reset;
    logic [3:0] bus_nib;
    logic [INDEX_W-1:0] index_value;
    logic [ROW_POINTER_W-1:0] row_pointer;
    logic index_modify_enable;
    logic row_pointer_enable;

    function automatic logic bus_write_to(input bus_phase_s ph, input logic [7:0] idx);
        bus_write_to = ph.valid && ph.write && (ph.index == idx);
    endfunction

    // Soft resets act only when the clock runs; a stopped clock simply holds every flop
    // combined reset of all three sources
    assign any_reset = RESET_IN || WATCHDOG_RESET_IN || CE_RESET_IN;
    assign bus_nib = HWDATA_IN[3:0];

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_phase = '0;
        if (HSEL_IN && HREADY_IN && (HTRANS_IN == HTRANS_NONSEQ || HTRANS_IN == HTRANS_SEQ))
        begin
            nxt_phase.valid = 1'b1;
            nxt_phase.write = HWRITE_IN;
            nxt_phase.index = HADDR_IN[ADDR_SHIFT+7:ADDR_SHIFT];
        end
    end

    // Phases advance only on a ready bus, so wait states of another slave
    // never let a later address phase overwrite one still pending here
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RESET_IN)
        begin
            phase_ff <= '0;
        end
        else if (HREADY_IN)
        begin
            phase_ff <= nxt_phase;
        end
    end

    // Zero wait states: every transfer completes in its first data-phase cycle
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT = HRESP_OKAY;

    // Read data is a mux of the flops themselves, so a write that ends one
    // data phase is already visible to a read whose data phase follows it
    // fixed-address access
    always_comb
    begin
        HRDATA_OUT = 32'h0000_0000;
        if (phase_ff.valid && !phase_ff.write)
        begin
            case (phase_ff.index)
                IDX_WINDOW_STAGING: HRDATA_OUT[3:0] = window_staging_ff;
                IDX_DATA_BANK_SELECT: HRDATA_OUT[3:0] = data_bank_select_ff;
                IDX_INDEX_HIGH_POINTER_HIGH: HRDATA_OUT[3:0] = index_high_ff;
                IDX_INDEX_MID_POINTER_LOW: HRDATA_OUT[3:0] = index_mid_ff;
                IDX_INDEX_LOW: HRDATA_OUT[3:0] = index_low_ff;
                IDX_PROGRAM_STATUS_WORD: HRDATA_OUT[3:0] = program_status_word_ff;
                default: HRDATA_OUT = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Window staging register
    // ------------------------------------------------------------------
    // Only power-on reset clears it; watchdog and chip-enable resets retain it
    // window storage
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RESET_IN)
        begin
            window_staging_ff <= RST_WINDOW_STAGING;
        end
        else if (fetch_pending_ff)
        begin
            window_staging_ff <= REGFILE_READ_DATA_IN;
        end
        else if (bus_write_to(phase_ff, IDX_WINDOW_STAGING))
        begin
            window_staging_ff <= bus_nib;
        end
    end

    // ------------------------------------------------------------------
    // Register-file transfer sequencing
    // ------------------------------------------------------------------
    // The read is two cycles: address out, then data captured, so the regfile may be a plain flop array
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            fetch_pending_ff <= 1'b0;
        end
        else
        begin
            fetch_pending_ff <= REGFILE_READ_INSTR_IN;
        end
    end

    // The address is held after a transfer so the file may keep decoding it
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RESET_IN)
        begin
            regfile_addr_ff <= '0;
        end
        else if (REGFILE_READ_INSTR_IN || REGFILE_WRITE_INSTR_IN)
        begin
            regfile_addr_ff <= REGFILE_OPERAND_IN;
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            regfile_wen_ff <= 1'b0;
            regfile_wdata_ff <= 4'h0;
        end
        else
        begin
            regfile_wen_ff <= REGFILE_WRITE_INSTR_IN;
            if (REGFILE_WRITE_INSTR_IN)
            begin
                regfile_wdata_ff <= window_staging_ff;
            end
        end
    end

    assign REGFILE_ADDR_OUT = regfile_addr_ff;
    assign REGFILE_WRITE_EN_OUT = regfile_wen_ff;
    assign REGFILE_WRITE_DATA_OUT = regfile_wdata_ff;

    // ------------------------------------------------------------------
    // Bank select
    // ------------------------------------------------------------------
    // bank storage
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            data_bank_select_ff <= RST_DATA_BANK_SELECT;
        end
        else if (bus_write_to(phase_ff, IDX_DATA_BANK_SELECT))
        begin
            data_bank_select_ff <= bus_nib;
        end
    end

    // Absent banks are not trapped: software keeps clear of them
    // binary bank number
    assign DATA_BANK_OUT = data_bank_select_ff;

    // ------------------------------------------------------------------
    // Index register and row pointer
    // ------------------------------------------------------------------
    // One set of flops serves both views, so there is no copy to fall out of step
    // shared storage
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            index_high_ff <= RST_INDEX_HIGH;
            index_mid_ff <= RST_INDEX_MID;
            index_low_ff <= RST_INDEX_LOW;
        end
        else
        begin
            if (bus_write_to(phase_ff, IDX_INDEX_HIGH_POINTER_HIGH))
            begin
                index_high_ff <= bus_nib;
            end
            if (bus_write_to(phase_ff, IDX_INDEX_MID_POINTER_LOW))
            begin
                index_mid_ff <= bus_nib;
            end
            if (bus_write_to(phase_ff, IDX_INDEX_LOW))
            begin
                index_low_ff <= bus_nib;
            end
        end
    end

    // Only bit 0 is owned here; the other status bits are plain storage for the core
    // status word
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            program_status_word_ff <= RST_PROGRAM_STATUS_WORD;
        end
        else if (bus_write_to(phase_ff, IDX_PROGRAM_STATUS_WORD))
        begin
            program_status_word_ff <= bus_nib;
        end
    end

    // Bit 3 of 7AH is the pointer enable and stays out of both assembled values
    // index assembly
    assign index_value = {index_high_ff[2:0], index_mid_ff, index_low_ff};
    assign row_pointer = {index_high_ff[2:0], index_mid_ff};
    assign row_pointer_enable = index_high_ff[ROW_POINTER_ENABLE_BIT];
    assign index_modify_enable = program_status_word_ff[INDEX_MODIFY_ENABLE_BIT];

    assign INDEX_VALUE_OUT = index_value;
    assign INDEX_MODIFY_ENABLE_OUT = index_modify_enable;
    assign ROW_POINTER_OUT = row_pointer;
    assign ROW_POINTER_ENABLE_OUT = row_pointer_enable;

    // ------------------------------------------------------------------
    // Address modification
    // ------------------------------------------------------------------
    // Real addresses are registered and hold until the next request, so the
    // core may sample them at any point of the cycle that follows its request
    // OR with index
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            dm_real_ff <= '0;
        end
        else if (DM_ACCESS_IN)
        begin
            if (index_modify_enable)
            begin
                dm_real_ff <= dm_addr_s'(DM_ADDR_IN | index_value);
            end
            else
            begin
                dm_real_ff <= DM_ADDR_IN;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (any_reset)
        begin
            gr_real_ff <= '0;
        end
        else if (GR_INDIRECT_IN)
        begin
            if (row_pointer_enable)
            begin
                gr_real_ff <= {row_pointer, GR_INDIRECT_ADDR_IN.column};
            end
            else
            begin
                gr_real_ff <= GR_INDIRECT_ADDR_IN;
            end
        end
    end

    assign DM_REAL_ADDR_OUT = dm_real_ff;
    assign GR_REAL_ADDR_OUT = gr_real_ff;

endmodule

// ---- sysptr_pkg.sv ----
// Package: register map, field layout, reset values and carrier types of the pointer register bank
package sysptr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_WINDOW_STAGING = 8'h78;
    localparam logic [7:0] IDX_DATA_BANK_SELECT = 8'h79;
    localparam logic [7:0] IDX_INDEX_HIGH_POINTER_HIGH = 8'h7a;
    localparam logic [7:0] IDX_INDEX_MID_POINTER_LOW = 8'h7b;
    localparam logic [7:0] IDX_INDEX_LOW = 8'h7c;
    localparam logic [7:0] IDX_PROGRAM_STATUS_WORD = 8'h7f;
    localparam int ADDR_SHIFT = 2;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ROW_POINTER_ENABLE_BIT = 3;
    localparam int INDEX_MODIFY_ENABLE_BIT = 0;
    localparam int NIBBLE_W = 4;
    localparam int INDEX_W = 11;
    localparam int ROW_POINTER_W = 7;
    localparam int REGFILE_ADDR_W = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_WINDOW_STAGING = 4'h0;
    localparam logic [3:0] RST_DATA_BANK_SELECT = 4'h0;
    localparam logic [3:0] RST_INDEX_HIGH = 4'h0;
    localparam logic [3:0] RST_INDEX_MID = 4'h0;
    localparam logic [3:0] RST_INDEX_LOW = 4'h0;
    localparam logic [3:0] RST_PROGRAM_STATUS_WORD = 4'h0;

    // ------------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] bank;
        logic [2:0] row;
        logic [3:0] column;
    } dm_addr_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] index;
    } bus_phase_s;

endpackage

// ---- cpu_system_pointer_registers_properties.sv ----
// Checker: port-level properties of the pointer register bank
`timescale 1ns/10ps

module cpu_system_pointer_registers_properties
(
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    input wire logic WATCHDOG_RESET_IN,
    input wire logic CE_RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic REGFILE_READ_INSTR_IN,
    input wire logic REGFILE_WRITE_INSTR_IN,
    input wire logic [sysptr_pkg::REGFILE_ADDR_W-1:0] REGFILE_OPERAND_IN,
    input wire logic [3:0] REGFILE_READ_DATA_IN,
    input wire logic [sysptr_pkg::REGFILE_ADDR_W-1:0] REGFILE_ADDR_OUT,
    input wire logic REGFILE_WRITE_EN_OUT,
    input wire logic [3:0] REGFILE_WRITE_DATA_OUT,
    input wire logic DM_ACCESS_IN,
    input wire sysptr_pkg::dm_addr_s DM_ADDR_IN,
    input wire sysptr_pkg::dm_addr_s DM_REAL_ADDR_OUT,
    input wire logic GR_INDIRECT_IN,
    input wire sysptr_pkg::dm_addr_s GR_INDIRECT_ADDR_IN,
    input wire sysptr_pkg::dm_addr_s GR_REAL_ADDR_OUT,
    input wire logic [3:0] DATA_BANK_OUT,
    input wire logic [sysptr_pkg::INDEX_W-1:0] INDEX_VALUE_OUT,
    input wire logic INDEX_MODIFY_ENABLE_OUT,
    input wire logic [sysptr_pkg::ROW_POINTER_W-1:0] ROW_POINTER_OUT,
    input wire logic ROW_POINTER_ENABLE_OUT
);
    import sysptr_pkg::*;

    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    // Every reset source disables the checks, so no check spans one; only power-on reset clears a pending bus phase
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (RESET_IN || WATCHDOG_RESET_IN || CE_RESET_IN);

    sequence bus_write_at(logic [31:0] a);
        HSEL_IN && HREADY_IN && HTRANS_IN[1] && HWRITE_IN && HADDR_IN == a;
    endsequence

    sequence fetch_then_store;
        REGFILE_READ_INSTR_IN ##2 REGFILE_WRITE_INSTR_IN;
    endsequence

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    a_store_pulse: assert property (REGFILE_WRITE_INSTR_IN |=>
        REGFILE_WRITE_EN_OUT && REGFILE_ADDR_OUT == $past(REGFILE_OPERAND_IN)) else $error("store pulse wrong");
    a_fetch_addr: assert property (REGFILE_READ_INSTR_IN |=>
        REGFILE_ADDR_OUT == $past(REGFILE_OPERAND_IN)) else $error("fetch address wrong");
    a_fetch_store_data: assert property (fetch_then_store |=>
        REGFILE_WRITE_DATA_OUT == $past(REGFILE_READ_DATA_IN, 2)) else $error("window transfer wrong");
    a_bank_write: assert property (bus_write_at({22'h0, IDX_DATA_BANK_SELECT, 2'h0}) |=> ##1
        DATA_BANK_OUT == $past(HWDATA_IN[3:0])) else $error("bank write lost");
    a_pointer_high_write: assert property (bus_write_at({22'h0, IDX_INDEX_HIGH_POINTER_HIGH, 2'h0}) |=> ##1
        ROW_POINTER_ENABLE_OUT == $past(HWDATA_IN[3]) && ROW_POINTER_OUT[6:4] == $past(HWDATA_IN[2:0]))
        else $error("pointer high write lost");
    a_status_write: assert property (bus_write_at({22'h0, IDX_PROGRAM_STATUS_WORD, 2'h0}) |=> ##1
        INDEX_MODIFY_ENABLE_OUT == $past(HWDATA_IN[0])) else $error("status flag write lost");
    a_index_low_write: assert property (bus_write_at({22'h0, IDX_INDEX_LOW, 2'h0}) |=> ##1
        INDEX_VALUE_OUT[3:0] == $past(HWDATA_IN[3:0])) else $error("index low write lost");
    a_dm_modify: assert property (DM_ACCESS_IN |=> DM_REAL_ADDR_OUT == ($past(INDEX_MODIFY_ENABLE_OUT) ?
        ($past(DM_ADDR_IN) | $past(INDEX_VALUE_OUT)) : $past(DM_ADDR_IN))) else $error("real address wrong");
    a_gr_replace: assert property (GR_INDIRECT_IN |=> GR_REAL_ADDR_OUT == ($past(ROW_POINTER_ENABLE_OUT) ?
        {$past(ROW_POINTER_OUT), $past(GR_INDIRECT_ADDR_IN.column)} : $past(GR_INDIRECT_ADDR_IN)))
        else $error("indirect address wrong");
    a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT && HRDATA_OUT[31:4] == 28'h0)
        else $error("bus response wrong");
endmodule

bind cpu_system_pointer_registers cpu_system_pointer_registers_properties cpu_system_pointer_registers_properties_i (.*);

// ---- cpu_system_pointer_registers_test.sv ----
// Testbench: pointer register bank against a behavioural model
`timescale 1ns/10ps

module cpu_system_pointer_registers_test;
    import sysptr_pkg::*;

    logic clk = 1'b0, rst = 1'b1, wdr = 1'b0, cer = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic rd = 1'b0, wrq = 1'b0, dma = 1'b0, gra = 1'b0, hready, hresp, wen, ime, rpe;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [6:0] opnd = 7'h0, radr, mpo;
    logic [3:0] rdat, wdat, bank;
    logic [10:0] ixo;
    dm_addr_s dmi = '0, gri = '0, dmo, gro;
    logic [3:0] mdl [8];
    logic [3:0] fmem [128];
    logic [3:0] em [128];
    int miscompares = 0, checks = 0;

    cpu_system_pointer_registers cpu_system_pointer_registers_i (
        .SYS_CLK_IN(clk), .RESET_IN(rst), .WATCHDOG_RESET_IN(wdr), .CE_RESET_IN(cer), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(HSIZE_WORD), .HREADY_IN(hready),
        .HWDATA_IN(hwdata), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .REGFILE_READ_INSTR_IN(rd), .REGFILE_WRITE_INSTR_IN(wrq), .REGFILE_OPERAND_IN(opnd),
        .REGFILE_READ_DATA_IN(rdat), .REGFILE_ADDR_OUT(radr), .REGFILE_WRITE_EN_OUT(wen),
        .REGFILE_WRITE_DATA_OUT(wdat), .DM_ACCESS_IN(dma), .DM_ADDR_IN(dmi), .DM_REAL_ADDR_OUT(dmo),
        .GR_INDIRECT_IN(gra), .GR_INDIRECT_ADDR_IN(gri), .GR_REAL_ADDR_OUT(gro), .DATA_BANK_OUT(bank),
        .INDEX_VALUE_OUT(ixo), .INDEX_MODIFY_ENABLE_OUT(ime), .ROW_POINTER_OUT(mpo), .ROW_POINTER_ENABLE_OUT(rpe)
    );

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Register file beside the block, written by the block's stores
    // ------------------------------------------------------------------
    assign rdat = fmem[radr];
    always @(posedge clk)
        if (wen === 1'b1)
            fmem[radr] <= wdat;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: expected %h got %h", $time, exp, got);
            miscompares++;
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] ra, input logic [3:0] d);
        int k;
        k = ra - 8'h78;
        hsel <= 1'b1;
        haddr <= {22'h0, ra, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {28'h0, d};
        do @(posedge clk); while (hready !== 1'b1);
        if (!w)
            chk(mdl[k], hrdata);
        else if (k != 5 && k != 6)
            mdl[k] = d;
    endtask

    task automatic file_get(input logic [6:0] op);
        rd <= 1'b1;
        opnd <= op;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(op, radr);
        mdl[0] = em[op];
    endtask

    task automatic file_put(input logic [6:0] op);
        wrq <= 1'b1;
        opnd <= op;
        @(posedge clk);
        wrq <= 1'b0;
        @(posedge clk);
        chk({1'b1, op, mdl[0]}, {wen, radr, wdat});
        em[op] = mdl[0];
    endtask

    // Also checks the register views, which are stable across these edges
    task automatic modify(input dm_addr_s d, input dm_addr_s g);
        logic [10:0] iv, dv, gv;
        dv = d;
        gv = g;
        iv = {mdl[2][2:0], mdl[3], mdl[4]};
        dma <= 1'b1;
        gra <= 1'b1;
        dmi <= d;
        gri <= g;
        @(posedge clk);
        dma <= 1'b0;
        gra <= 1'b0;
        @(posedge clk);
        chk(mdl[7][0] ? (dv | iv) : dv, dmo);
        chk(mdl[2][3] ? {iv[10:4], gv[3:0]} : gv, gro);
        chk(iv, ixo);
        chk(iv[10:4], mpo);
        chk({mdl[2][3], mdl[2][2:0], mdl[3]}, {rpe, mpo});
        chk({mdl[7][0], mdl[2][3], mdl[1]}, {ime, rpe, bank});
    endtask

    // Source 0 power-on, 1 watchdog, 2 chip-enable, 3 none
    task automatic hit(input int which);
        rst <= (which == 0);
        wdr <= (which == 1);
        cer <= (which == 2);
        @(posedge clk);
        rst <= 1'b0;
        wdr <= 1'b0;
        cer <= 1'b0;
        @(posedge clk);
        for (int i = 1; i < 8; i++)
            mdl[i] = 4'h0;
        if (which == 0)
            mdl[0] = 4'h0;
        for (int i = 0; i < 8; i++)
            bus(1'b0, 8'h78 + 8'(i), 4'h0);
        modify(dm_addr_s'(11'h7ff), dm_addr_s'(11'h7ff));
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(2));
        for (int i = 0; i < 128; i++)
        begin
            fmem[i] = 4'($urandom);
            em[i] = fmem[i];
        end
        mdl = '{default: 4'h0};
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        hit(3);
        for (int v = 0; v < 16; v++)
        begin
            bus(1'b1, 8'h79, 4'(v));
            bus(1'b0, 8'h79, 4'h0);
            chk(v, bank);
        end
        repeat (60)
        begin
            bus(1'b1, 8'h78 + 8'($urandom_range(7)), 4'($urandom));
            bus(1'b0, 8'h78 + 8'($urandom_range(7)), 4'h0);
            file_get(7'($urandom));
            file_put(7'($urandom));
            modify(dm_addr_s'(11'($urandom)), dm_addr_s'(11'($urandom)));
        end
        bus(1'b1, 8'h7a, 4'hf);
        file_get(7'h15);
        hit(1);
        bus(1'b1, 8'h7f, 4'hf);
        hit(2);
        hit(0);
        give_verdict();
    end

    initial
    begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule
